// ---- include/asac_pkg.sv ----
// Shared constants and types of the address space access checker
package asac_pkg;

  // ==========================================================
  // Access kinds and sizes
  typedef enum logic [1:0] {
    ASAC_FETCH = 2'b00,
    ASAC_LOAD = 2'b01,
    ASAC_STORE = 2'b10,
    ASAC_LDST = 2'b11
  } asac_kind_t;

  typedef enum logic [2:0] {
    ASAC_BYTE = 3'b000,
    ASAC_HALF = 3'b001,
    ASAC_WORD = 3'b010,
    ASAC_XWORD = 3'b011,
    ASAC_DWORD = 3'b100,
    ASAC_QUAD = 3'b101
  } asac_size_t;

  // ==========================================================
  // Alignment masks on the low offset bits
  localparam logic [3:0] ASAC_MASK_BYTE = 4'h0;
  localparam logic [3:0] ASAC_MASK_HALF = 4'h1;
  localparam logic [3:0] ASAC_MASK_WORD = 4'h3;
  localparam logic [3:0] ASAC_MASK_DWORD = 4'h7;
  localparam logic [3:0] ASAC_MASK_QUAD = 4'hF;

  // ==========================================================
  // Space identifier codes and privilege ranges
  localparam logic [7:0] ASAC_PRIMARY_SPACE_ID = 8'h80;
  localparam logic [7:0] ASAC_SECONDARY_SPACE_ID = 8'h81;
  localparam logic [7:0] ASAC_PRIMARY_NOFAULT_SPACE_ID = 8'h82;
  localparam logic [7:0] ASAC_SECONDARY_NOFAULT_SPACE_ID = 8'h83;
  localparam logic [7:0] ASAC_PRIMARY_LITTLE_SPACE_ID = 8'h88;
  localparam logic [7:0] ASAC_SECONDARY_LITTLE_SPACE_ID = 8'h89;
  localparam logic [7:0] ASAC_PRIMARY_NOFAULT_LITTLE_SPACE_ID = 8'h8A;
  localparam logic [7:0] ASAC_SECONDARY_NOFAULT_LITTLE_SPACE_ID = 8'h8B;
  localparam logic [7:0] ASAC_NUCLEUS_SPACE_ID = 8'h04;
  localparam logic [7:0] ASAC_NUCLEUS_LITTLE_SPACE_ID = 8'h0C;
  localparam logic [7:0] ASAC_PRIV_BAN_LO = 8'h30;
  localparam logic [7:0] ASAC_PRIV_BAN_HI = 8'h7F;
  localparam int ASAC_UNRESTRICTED_BIT = 7;
  localparam int ASAC_LITTLE_BIT = 3;
  localparam logic [2:0] ASAC_MAX_PRIVILEGED_TRAP_LEVEL = 3'h2;

  // ==========================================================
  // Register offsets (byte addresses on the APB)
  localparam logic [7:0] ASAC_CTRL_OFF = 8'h00;
  localparam logic [7:0] ASAC_SPACE_ID_REG_OFF = 8'h04;
  localparam logic [7:0] ASAC_PRIMARY_CONTEXT_OFF = 8'h08;
  localparam logic [7:0] ASAC_SECONDARY_CONTEXT_OFF = 8'h0C;
  localparam logic [7:0] ASAC_STATUS_OFF = 8'h10;
  localparam logic [7:0] ASAC_ACCESS_COUNT_OFF = 8'h14;
  localparam logic [7:0] ASAC_TRAP_COUNT_OFF = 8'h18;

  // Control register fields
  localparam int ASAC_CTRL_PRIV_POS = 0;
  localparam int ASAC_CTRL_CLE_POS = 1;
  localparam int ASAC_CTRL_TL_POS = 2;
  localparam int ASAC_CONTEXT_W = 13;

  // Reset values
  localparam logic [7:0] ASAC_SPACE_ID_REG_RST = 8'h80;
  localparam logic [2:0] ASAC_TL_RST = 3'h0;
  localparam logic ASAC_PRIV_RST = 1'b1;
  localparam logic [12:0] ASAC_CONTEXT_RST = 13'h0000;

endpackage

// ---- verilog/asac_checker.sv ----
// Address space selection, alignment and privilege checking of one access
// ==========================================================
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ns
module asac_checker (
  input wire logic sys_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Access request from issue logic
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [2:0] req_size,
  input wire logic req_alt,
  input wire logic req_imm_form,
  input wire logic [7:0] req_insn_space_id,
  input wire logic req_twin_permit,
  input wire logic [63:0] req_offset,
  // Access toward the translation unit
  output logic mem_valid,
  output logic [1:0] mem_kind,
  output logic [2:0] mem_size,
  output logic [7:0] mem_space_identifier,
  output logic [63:0] mem_offset,
  output logic [12:0] mem_context,
  output logic mem_little,
  output logic mem_nofault,
  output logic mem_atomic,
  output logic [60:0] mem_order_granule,
  // Trap report
  output logic trap_valid,
  output logic trap_misaligned,
  output logic trap_privilege,
  output logic [7:0] trap_space_identifier
);

  // ==========================================================
  // State
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic privilege_flag;
    logic endianness_default_flag;
    logic [2:0] trap_level;
    logic [7:0] space_id_reg;
    logic [12:0] primary_context;
    logic [12:0] secondary_context;
    logic last_misaligned;
    logic last_privilege;
    logic [7:0] last_space_id;
    logic [31:0] access_count;
    logic [31:0] trap_count;
    logic mem_valid;
    logic [1:0] mem_kind;
    logic [2:0] mem_size;
    logic [7:0] mem_space_identifier;
    logic [63:0] mem_offset;
    logic [12:0] mem_context;
    logic mem_little;
    logic mem_nofault;
    logic mem_atomic;
    logic trap_valid;
    logic trap_misaligned;
    logic trap_privilege;
    logic [7:0] trap_space_identifier;
  } asac_state_t;

  asac_state_t st;
  asac_state_t next_st;

  logic [7:0] sel_id;
  logic [3:0] align_mask;
  logic misaligned;
  logic priv_bad;
  logic trap_now;
  logic is_nofault_id;
  logic is_secondary_id;
  logic is_nucleus_id;
  logic apb_access;
  logic apb_hit;
  logic [31:0] rd_word;
  logic [31:0] wr_word;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;

  // ==========================================================
  // Space identifier selection
  always_comb begin
    sel_id = asac_pkg::ASAC_PRIMARY_SPACE_ID;
    if (req_alt) begin
      sel_id = req_imm_form ? st.space_id_reg : req_insn_space_id;
    end else if (req_kind == asac_pkg::ASAC_FETCH) begin
      if (st.privilege_flag && st.trap_level != 3'h0) begin
        sel_id = asac_pkg::ASAC_NUCLEUS_SPACE_ID;
      end else begin
        sel_id = asac_pkg::ASAC_PRIMARY_SPACE_ID;
      end
    end else if (st.privilege_flag && st.trap_level != 3'h0) begin
      sel_id = st.endianness_default_flag ? asac_pkg::ASAC_NUCLEUS_LITTLE_SPACE_ID
                                          : asac_pkg::ASAC_NUCLEUS_SPACE_ID;
    end else begin
      sel_id = st.endianness_default_flag ? asac_pkg::ASAC_PRIMARY_LITTLE_SPACE_ID
                                          : asac_pkg::ASAC_PRIMARY_SPACE_ID;
    end
  end

  // ==========================================================
  // Alignment check
  always_comb begin
    case (req_size)
      asac_pkg::ASAC_HALF: align_mask = asac_pkg::ASAC_MASK_HALF;
      asac_pkg::ASAC_WORD: align_mask = asac_pkg::ASAC_MASK_WORD;
      asac_pkg::ASAC_XWORD: align_mask = asac_pkg::ASAC_MASK_DWORD;
      asac_pkg::ASAC_DWORD: align_mask = asac_pkg::ASAC_MASK_DWORD;
      asac_pkg::ASAC_QUAD: align_mask = asac_pkg::ASAC_MASK_QUAD;
      default: align_mask = asac_pkg::ASAC_MASK_BYTE;
    endcase
    if (req_kind == asac_pkg::ASAC_FETCH) begin
      align_mask = asac_pkg::ASAC_MASK_WORD;
    end
  end

  // misalignment traps unless permitted
  // Twin loads may sit on eight-byte boundaries only, never below that
  assign misaligned = req_twin_permit && req_size == asac_pkg::ASAC_QUAD
                      && req_kind == asac_pkg::ASAC_LOAD
                      ? |(req_offset[3:0] & asac_pkg::ASAC_MASK_DWORD)
                      : |(req_offset[3:0] & align_mask);

  // ==========================================================
  // Privilege check
  always_comb begin
    if (!st.privilege_flag) begin
      priv_bad = !sel_id[asac_pkg::ASAC_UNRESTRICTED_BIT];
    end else begin
      priv_bad = sel_id >= asac_pkg::ASAC_PRIV_BAN_LO && sel_id <= asac_pkg::ASAC_PRIV_BAN_HI;
    end
  end

  assign trap_now = req_valid && (misaligned || priv_bad);

  // Identifier classes
  assign is_nofault_id = sel_id == asac_pkg::ASAC_PRIMARY_NOFAULT_SPACE_ID
                      || sel_id == asac_pkg::ASAC_SECONDARY_NOFAULT_SPACE_ID
                      || sel_id == asac_pkg::ASAC_PRIMARY_NOFAULT_LITTLE_SPACE_ID
                      || sel_id == asac_pkg::ASAC_SECONDARY_NOFAULT_LITTLE_SPACE_ID;
  assign is_secondary_id = sel_id == asac_pkg::ASAC_SECONDARY_SPACE_ID
                        || sel_id == asac_pkg::ASAC_SECONDARY_LITTLE_SPACE_ID
                        || sel_id == asac_pkg::ASAC_SECONDARY_NOFAULT_SPACE_ID
                        || sel_id == asac_pkg::ASAC_SECONDARY_NOFAULT_LITTLE_SPACE_ID;
  assign is_nucleus_id = sel_id == asac_pkg::ASAC_NUCLEUS_SPACE_ID
                      || sel_id == asac_pkg::ASAC_NUCLEUS_LITTLE_SPACE_ID;

  // ==========================================================
  // APB decode
  assign apb_access = psel && penable && !st.pready;
  assign ctrl_word = {27'h0000000, st.trap_level, st.endianness_default_flag,
                      st.privilege_flag};
  assign status_word = {22'h000000, st.last_space_id, st.last_privilege, st.last_misaligned};

  // Byte lanes merge into the addressed word
  always_comb begin
    rd_word = 32'h00000000;
    apb_hit = 1'b1;
    case (paddr)
      asac_pkg::ASAC_CTRL_OFF: rd_word = ctrl_word;
      asac_pkg::ASAC_SPACE_ID_REG_OFF: rd_word = {24'h000000, st.space_id_reg};
      asac_pkg::ASAC_PRIMARY_CONTEXT_OFF: rd_word = {19'h00000, st.primary_context};
      asac_pkg::ASAC_SECONDARY_CONTEXT_OFF: rd_word = {19'h00000, st.secondary_context};
      asac_pkg::ASAC_STATUS_OFF: rd_word = status_word;
      asac_pkg::ASAC_ACCESS_COUNT_OFF: rd_word = st.access_count;
      asac_pkg::ASAC_TRAP_COUNT_OFF: rd_word = st.trap_count;
      default: apb_hit = 1'b0;
    endcase
    for (int i = 0; i < 4; i++) begin
      wr_word[i*8 +: 8] = pstrb[i] ? pwdata[i*8 +: 8] : rd_word[i*8 +: 8];
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    // APB: one wait state, answer registered
    next_st.pready = apb_access;
    next_st.pslverr = apb_access && !apb_hit;
    next_st.prdata = (apb_access && !pwrite) ? rd_word : 32'h00000000;
    if (apb_access && pwrite) begin
      case (paddr)
        asac_pkg::ASAC_CTRL_OFF: begin
          next_st.privilege_flag = wr_word[asac_pkg::ASAC_CTRL_PRIV_POS];
          next_st.endianness_default_flag = wr_word[asac_pkg::ASAC_CTRL_CLE_POS];
          next_st.trap_level = wr_word[asac_pkg::ASAC_CTRL_TL_POS +: 3];
        end
        asac_pkg::ASAC_SPACE_ID_REG_OFF: next_st.space_id_reg = wr_word[7:0];
        asac_pkg::ASAC_PRIMARY_CONTEXT_OFF: begin
          next_st.primary_context = wr_word[asac_pkg::ASAC_CONTEXT_W-1:0];
        end
        asac_pkg::ASAC_SECONDARY_CONTEXT_OFF: begin
          next_st.secondary_context = wr_word[asac_pkg::ASAC_CONTEXT_W-1:0];
        end
        // Counters clear on any write
        asac_pkg::ASAC_ACCESS_COUNT_OFF: next_st.access_count = 32'h00000000;
        asac_pkg::ASAC_TRAP_COUNT_OFF: next_st.trap_count = 32'h00000000;
        default: next_st.pslverr = next_st.pslverr;
      endcase
    end

    // a trapping access never reaches memory
    next_st.mem_valid = req_valid && !trap_now;
    next_st.trap_valid = trap_now;
    next_st.trap_misaligned = trap_now && misaligned;
    next_st.trap_privilege = trap_now && priv_bad;
    next_st.trap_space_identifier = trap_now ? sel_id : 8'h00;
    if (req_valid) begin
      next_st.mem_kind = req_kind;
      next_st.mem_size = req_size;
      next_st.mem_space_identifier = sel_id;
      next_st.mem_offset = req_offset;
      if (is_nucleus_id) begin
        next_st.mem_context = asac_pkg::ASAC_CONTEXT_RST;
      end else begin
        next_st.mem_context = is_secondary_id ? st.secondary_context : st.primary_context;
      end
      next_st.mem_little = sel_id[asac_pkg::ASAC_LITTLE_BIT] && sel_id[7];
      next_st.mem_nofault = is_nofault_id && req_kind == asac_pkg::ASAC_LOAD;
      next_st.mem_atomic = !misaligned && req_size != asac_pkg::ASAC_QUAD;
      next_st.access_count = st.access_count + 32'h00000001;
    end
    if (trap_now) begin
      // Event wins over a software clear in the same cycle
      next_st.trap_count = st.trap_count + 32'h00000001;
      next_st.last_misaligned = misaligned;
      next_st.last_privilege = priv_bad;
      next_st.last_space_id = sel_id;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st <= '0;
      st.privilege_flag <= asac_pkg::ASAC_PRIV_RST;
      st.trap_level <= asac_pkg::ASAC_TL_RST;
      st.space_id_reg <= asac_pkg::ASAC_SPACE_ID_REG_RST;
      st.primary_context <= asac_pkg::ASAC_CONTEXT_RST;
      st.secondary_context <= asac_pkg::ASAC_CONTEXT_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  assign pready = st.pready;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;
  assign mem_valid = st.mem_valid;
  assign mem_kind = st.mem_kind;
  assign mem_size = st.mem_size;
  assign mem_space_identifier = st.mem_space_identifier;
  assign mem_offset = st.mem_offset;
  assign mem_context = st.mem_context;
  assign mem_little = st.mem_little;
  assign mem_nofault = st.mem_nofault;
  assign mem_atomic = st.mem_atomic;
  assign mem_order_granule = st.mem_offset[63:3];
  assign trap_valid = st.trap_valid;
  assign trap_misaligned = st.trap_misaligned;
  assign trap_privilege = st.trap_privilege;
  assign trap_space_identifier = st.trap_space_identifier;

endmodule

// ---- test/asac_access_checker.sv ----
// Concurrent checks on the access checker ports
`timescale 1ns/1ns
module asac_access_checks (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic [2:0] req_size,
  input wire logic [63:0] req_offset,
  input wire logic req_twin_permit,
  input wire logic mem_valid,
  input wire logic [2:0] mem_size,
  input wire logic [63:0] mem_offset,
  input wire logic mem_atomic,
  input wire logic [60:0] mem_order_granule,
  input wire logic trap_valid,
  input wire logic trap_misaligned,
  input wire logic trap_privilege,
  input wire logic [7:0] trap_space_identifier
);
  // ==========================================================
  // Clocking and shared sequences
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_mis;
    trap_valid && trap_misaligned;
  endsequence
  sequence s_issue;
    req_valid ##1 mem_valid;
  endsequence
  // ==========================================================
  // Answer, alignment, offset, granule, atomic and privilege relations
  property p_one_answer;
    req_valid |=> mem_valid != trap_valid;
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("no single answer");
  property p_half;
    req_valid && req_size == 3'h1 && req_offset[0] |=> s_mis;
  endproperty
  a_half: assert property (p_half) else $error("odd halfword passed");
  property p_word;
    req_valid && req_size == 3'h2 && req_offset[1:0] != 2'h0 |=> s_mis;
  endproperty
  a_word: assert property (p_word) else $error("bad word passed");
  property p_dword;
    req_valid && req_size inside {3'h3, 3'h4} && req_offset[2:0] != 3'h0 |=> s_mis;
  endproperty
  a_dword: assert property (p_dword) else $error("bad doubleword passed");
  // Twin loads are one permitted quad exception, so leave them out; quad fetches, checked on the word mask only, are not left out
  property p_quad;
    req_valid && !req_twin_permit && req_size == 3'h5 && req_offset[3:0] != 4'h0 |=> s_mis;
  endproperty
  a_quad: assert property (p_quad) else $error("bad quadword passed");
  property p_offset;
    s_issue |-> mem_offset == $past(req_offset);
  endproperty
  a_offset: assert property (p_offset) else $error("offset altered");
  // Granule taken from the request, not from the output it is cut from
  property p_granule;
    s_issue |-> mem_order_granule == $past(req_offset[63:3]);
  endproperty
  a_granule: assert property (p_granule) else $error("wrong granule");
  property p_atomic;
    mem_valid |-> mem_atomic == (mem_size != 3'h5);
  endproperty
  a_atomic: assert property (p_atomic) else $error("wrong atomic flag");
  property p_priv_id;
    trap_valid && trap_privilege |-> !trap_space_identifier[7];
  endproperty
  a_priv_id: assert property (p_priv_id) else $error("open id refused");
endmodule

// ---- test/asac_mmu_model.sv ----
// Memory side model that takes every issued access
`timescale 1ns/1ns
module asac_mmu_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic mem_valid,
  output int n_taken
);
  // Count accepted accesses; never stalls, as the path has no ready
  always_ff @(posedge sys_clk) begin
    if (reset)
      n_taken <= 0;
    else if (mem_valid)
      n_taken <= n_taken + 1;
  end
endmodule

// ---- test/address_space_access_checker_test.sv ----
// Directed bench for the address space access checker
`timescale 1ns/1ns
module address_space_access_checker_test;
  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, req_valid = 1'h0, req_alt = 1'h0;
  logic req_imm_form = 1'h0, pready, pslverr, er, req_twin_permit = 1'h0;
  logic [7:0] paddr = 8'h00, req_insn_space_id = 8'h00, mem_space_identifier;
  logic [7:0] trap_space_identifier;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] req_kind = 2'h0, mem_kind;
  logic [2:0] req_size = 3'h0, mem_size;
  logic [63:0] req_offset = 64'h0, mem_offset;
  logic mem_valid, mem_little, mem_nofault, mem_atomic, trap_valid, trap_misaligned;
  logic trap_privilege;
  logic [12:0] mem_context;
  logic [60:0] mem_order_granule;
  int failures = 0, n_tests = 0, n_issue = 0, n_req = 0, n_trap = 0, n_taken;
  logic [7:0] ctl[5] = '{8'h01, 8'h03, 8'h05, 8'h0B, 8'h02};
  logic [7:0] fid[5] = '{8'h80, 8'h80, 8'h04, 8'h04, 8'h80};
  logic [7:0] did[5] = '{8'h80, 8'h88, 8'h04, 8'h0C, 8'h88};
  logic [1:0] knd[9] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
  logic [2:0] sz[9] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h2};
  logic [7:0] off[9] = '{8'h01, 8'h02, 8'h02, 8'h04, 8'h04, 8'h08, 8'h08, 8'h10, 8'h02};
  logic mis[9] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
  logic [7:0] pid[7] = '{8'h2F, 8'h30, 8'h7F, 8'h80, 8'h2F, 8'h7F, 8'hFF};
  logic ptr[7] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
  logic [7:0] cid[4] = '{8'h83, 8'h80, 8'h8A, 8'h82};
  logic [12:0] cctx[4] = '{13'h0456, 13'h0123, 13'h0123, 13'h0123};
  logic cnf[4] = '{1'h1, 1'h0, 1'h1, 1'h0};

  // ==========================================================
  // Design, partner model and clock
  asac_checker dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .req_valid(req_valid), .req_kind(req_kind),
    .req_size(req_size), .req_alt(req_alt), .req_imm_form(req_imm_form),
    .req_insn_space_id(req_insn_space_id), .req_twin_permit(req_twin_permit),
    .req_offset(req_offset),
    .mem_valid(mem_valid), .mem_kind(mem_kind), .mem_size(mem_size),
    .mem_space_identifier(mem_space_identifier), .mem_offset(mem_offset),
    .mem_context(mem_context), .mem_little(mem_little), .mem_nofault(mem_nofault),
    .mem_atomic(mem_atomic), .mem_order_granule(mem_order_granule), .trap_valid(trap_valid),
    .trap_misaligned(trap_misaligned), .trap_privilege(trap_privilege),
    .trap_space_identifier(trap_space_identifier));
  asac_mmu_model u_mmu (.sys_clk(sys_clk), .reset(reset), .mem_valid(mem_valid),
    .n_taken(n_taken));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Tasks
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Full APB transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    i = 0;
    @(posedge sys_clk);
    while (pready !== 1'h1 && i < 20) begin
      i++;
      @(posedge sys_clk);
    end
    if (i == 20) begin
      failures++;
      $display("Error at %0t: no bus answer", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // One access; answer stands in the cycle after the request
  task acc(input logic [1:0] k, input logic [2:0] s, input logic alt, input logic imm,
    input logic [7:0] id, input logic [63:0] o, input logic tr, input logic [7:0] eid);
    @(posedge sys_clk);
    req_valid <= 1'h1;
    req_kind <= k;
    req_size <= s;
    req_alt <= alt;
    req_imm_form <= imm;
    req_insn_space_id <= id;
    req_offset <= o;
    @(posedge sys_clk);
    req_valid <= 1'h0;
    #1;
    n_req++;
    chk(trap_valid, tr);
    chk(mem_valid, !tr);
    chk(tr ? trap_space_identifier : mem_space_identifier, eid);
    if (tr) n_trap++;
    else n_issue++;
  endtask
  task close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'h0;
    apb(1'h0, asac_pkg::ASAC_CTRL_OFF, 32'h0);
    chk(rd, 32'h1);
    apb(1'h0, asac_pkg::ASAC_SPACE_ID_REG_OFF, 32'h0);
    chk(rd, 32'h80);
    apb(1'h0, 8'h1C, 32'h0);
    chk(er, 1'h1);
    $display("reset and map test done");
    for (int i = 0; i < 5; i++) begin
      apb(1'h1, asac_pkg::ASAC_CTRL_OFF, {24'h0, ctl[i]});
      acc(2'h0, 3'h2, 1'h0, 1'h0, 8'h00, 64'h40, 1'h0, fid[i]);
      acc(2'h1, 3'h4, 1'h0, 1'h0, 8'h00, 64'h48, 1'h0, did[i]);
    end
    $display("implicit identifier test done");
    apb(1'h1, asac_pkg::ASAC_CTRL_OFF, 32'h1);
    for (int i = 0; i < 9; i++) begin
      acc(knd[i], sz[i], 1'h0, 1'h0, 8'h00, 64'(off[i]), mis[i], 8'h80);
      chk(trap_misaligned, mis[i]);
    end
    // Twin quad load passes on eight, still traps below it
    @(posedge sys_clk);
    req_twin_permit <= 1'h1;
    acc(2'h1, 3'h5, 1'h0, 1'h0, 8'h00, 64'h8, 1'h0, 8'h80);
    acc(2'h1, 3'h5, 1'h0, 1'h0, 8'h00, 64'h4, 1'h1, 8'h80);
    chk(trap_misaligned, 1'h1);
    @(posedge sys_clk);
    req_twin_permit <= 1'h0;
    $display("alignment test done");
    for (int i = 0; i < 7; i++) begin
      apb(1'h1, asac_pkg::ASAC_CTRL_OFF, (i < 4) ? 32'h1 : 32'h0);
      acc(2'h1, 3'h0, 1'h1, 1'h0, pid[i], 64'h3, ptr[i], pid[i]);
      chk(trap_privilege, ptr[i]);
    end
    apb(1'h1, asac_pkg::ASAC_SPACE_ID_REG_OFF, 32'h10);
    acc(2'h2, 3'h0, 1'h1, 1'h1, 8'hFF, 64'h0, 1'h1, 8'h10);
    $display("privilege test done");
    apb(1'h1, asac_pkg::ASAC_PRIMARY_CONTEXT_OFF, 32'h123);
    apb(1'h1, asac_pkg::ASAC_SECONDARY_CONTEXT_OFF, 32'h456);
    for (int i = 0; i < 4; i++) begin
      acc((i == 3) ? 2'h2 : 2'h1, 3'h2, 1'h1, 1'h0, cid[i], 64'h10, 1'h0, cid[i]);
      chk(mem_context, cctx[i]);
      chk(mem_nofault, cnf[i]);
      chk(mem_kind, (i == 3) ? 2'h2 : 2'h1);
      chk(mem_little, i == 2);
    end
    $display("context test done");
    apb(1'h0, asac_pkg::ASAC_ACCESS_COUNT_OFF, 32'h0);
    chk(rd, n_req);
    apb(1'h0, asac_pkg::ASAC_TRAP_COUNT_OFF, 32'h0);
    chk(rd, n_trap);
    chk(n_taken, n_issue);
    $display("count test done");
    close_out;
  end
  // Watchdog well beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    close_out;
  end
endmodule

bind asac_checker asac_access_checks u_rules (.sys_clk(sys_clk), .reset(reset),
  .req_valid(req_valid), .req_size(req_size), .req_offset(req_offset),
  .req_twin_permit(req_twin_permit),
  .mem_valid(mem_valid), .mem_size(mem_size), .mem_offset(mem_offset),
  .mem_atomic(mem_atomic), .mem_order_granule(mem_order_granule),
  .trap_valid(trap_valid), .trap_misaligned(trap_misaligned),
  .trap_privilege(trap_privilege), .trap_space_identifier(trap_space_identifier));
